// ---- fspc_ctrl.v ----
/*
  Flash sector protection controller: register slave, write guard, sector
  decode, protection checks and the erase/program sequencer on the array.
  Assumes a synchronous register port with read data one cycle later and
  an array interface that completes any operation within one cycle.
*/
// Functional notes
// - Erase is either the whole array at once or one sector, and programming writes one byte.
// - Erasing or programming one sector never alters any other sector.
// - In tool and in-circuit modes all sectors and the option byte may be changed.
// - In in-application mode sector 0 is refused while other sectors may be changed.
// - A 4K part has sector 0, an 8K part sectors 0 and 1, larger parts sectors 0 to 2.
// - Sectors 0 and 1 are 4 Kbytes each at the top, sector 0 at F000h-FFFFh with the vectors.
// - With read-out protection on, external reads return nothing and writes are refused.
// - Clearing read-out protection first erases the whole array and only then allows writes.
// - Read-out protection is set and cleared by one bit of the option byte.
// - A key sequence must arm the controls before each program or erase start.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defines.vh"

module fspc_ctrl #(
  parameter MEM_KB = 32
) (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        resetn,
  // Register port.
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  // Mode selection and external read path.
  input  wire [1:0]  prog_mode,
  input  wire        ext_read,
  input  wire [15:0] ext_addr,
  output reg  [7:0]  ext_rdata,
  // Flash array.
  output reg         arr_we,
  output reg  [15:0] arr_addr,
  output reg  [7:0]  arr_wdata,
  input  wire [7:0]  arr_rdata,
  output wire        readout_protect_bit
);

  // ----------------------------------------------------------------------
  // Sizing and states
  // ----------------------------------------------------------------------
  // The span is worked out at full width and only then cut to the
  // address bus, so a 64 Kbyte part gives a base of zero.
  localparam [31:0] MEM_SPAN  = MEM_KB * 1024;
  localparam [31:0] MEM_LOW   = 32'h0001_0000 - MEM_SPAN;
  localparam [15:0] MEM_BASE  = MEM_LOW[15:0];
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_ERASE = 4'h2;
  localparam [3:0] ST_PROG  = 4'h4;
  localparam [3:0] ST_OPT   = 4'h8;

  // Done and refused are only cleared by the next start, so software may
  // poll them at leisure after an operation.
  reg [3:0]  state;
  reg [1:0]  guard;
  reg [1:0]  cmd;
  reg        busy;
  reg        refused;
  reg        done;
  reg [7:0]  addr_lo;
  reg [7:0]  addr_hi;
  reg [7:0]  data_reg;
  reg [7:0]  option;
  reg [7:0]  opt_new;
  reg [15:0] walk;
  reg [15:0] walk_end;
  reg [1:0]  sector;
  reg        in_map;
  reg        allowed;

  wire [15:0] tgt = {addr_hi, addr_lo};
  wire        rdp = option[`FSPC_OPT_RDP_BIT];
  wire        armed = (guard == 2'h2);
  wire [1:0]  wcmd = reg_wdata[`FSPC_BIT_CMD_HI:`FSPC_BIT_CMD_LO];
  // A start is only taken while idle; one arriving mid-operation is dropped.
  wire        start = reg_write && (reg_addr == `FSPC_ADDR_CTRL_STATUS) &&
                      reg_wdata[`FSPC_BIT_START] && !busy;

  // The pin is a plain copy of the option bit, so it follows a new option at once.
  assign readout_protect_bit = rdp;

  // ----------------------------------------------------------------------
  // Sector decode
  // ----------------------------------------------------------------------
  // Sector 2 is the rest of the array below sector 1, so it spans whatever
  // the part size leaves beneath the two fixed 4 Kbyte sectors.
  always @* begin
    // A part of 64 Kbytes fills the whole map, so every address is present.
    in_map = (tgt >= MEM_BASE) || (MEM_KB >= 64);
    if (tgt >= `FSPC_SEC0_BASE) begin
      sector = 2'h0;
    end else if (tgt >= `FSPC_SEC1_BASE) begin
      sector = 2'h1;
    end else begin
      sector = 2'h2;
    end
    if (MEM_KB <= 4 && sector != 2'h0) begin
      in_map = 1'b0;
    end else if (MEM_KB <= 8 && sector == 2'h2) begin
      in_map = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Permission check
  // ----------------------------------------------------------------------
  // The option byte stays writable under protection so that it can be
  // cleared, which triggers the mass erase first.
  // A mass erase would wipe sector 0, so it is refused in application mode
  // just as a direct request on sector 0 is.
  always @* begin
    allowed = armed;
    if (cmd_pick_option(wcmd)) begin
      allowed = allowed && (prog_mode != `FSPC_MODE_IAP);
    end else if (rdp) begin
      allowed = 1'b0;
    end else if (wcmd == `FSPC_CMD_MASS) begin
      allowed = allowed && (prog_mode != `FSPC_MODE_IAP);
    end else begin
      allowed = allowed && in_map;
      if (prog_mode == `FSPC_MODE_IAP && sector == 2'h0) begin
        allowed = 1'b0;
      end
    end
  end

  // Kept as a function so the option test reads alike wherever it is used.
  function cmd_pick_option;
    input [1:0] c;
    begin
      cmd_pick_option = (c == `FSPC_CMD_OPTION);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers and sequencer
  // ----------------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state    <= ST_IDLE;
      guard    <= 2'h0;
      cmd      <= 2'h0;
      busy     <= 1'b0;
      refused  <= 1'b0;
      done     <= 1'b0;
      addr_lo  <= 8'h00;
      addr_hi  <= 8'h00;
      data_reg <= 8'h00;
      option   <= `FSPC_RST_OPTION;
      opt_new  <= 8'h00;
      walk     <= 16'h0000;
      walk_end <= 16'h0000;
      arr_we   <= 1'b0;
      arr_addr <= 16'h0000;
      arr_wdata <= 8'h00;
    end else begin
      arr_we <= 1'b0;
      // Both keys must arrive in a row; any other guard write drops the
      // guard, so a stray store can never launch an erase by itself.
      if (reg_write && reg_addr == `FSPC_ADDR_GUARD) begin
        if (reg_wdata == `FSPC_KEY1) begin
          guard <= 2'h1;
        end else if (reg_wdata == `FSPC_KEY2 && guard == 2'h1) begin
          guard <= 2'h2;
        end else begin
          guard <= 2'h0;
        end
      end
      if (reg_write && reg_addr == `FSPC_ADDR_ADDR_LO) begin
        addr_lo <= reg_wdata;
      end else if (reg_write && reg_addr == `FSPC_ADDR_ADDR_HI) begin
        addr_hi <= reg_wdata;
      end else if (reg_write && reg_addr == `FSPC_ADDR_DATA) begin
        data_reg <= reg_wdata;
      end
      if (start) begin
        // A refused start disarms as well, so every attempt needs fresh keys.
        guard <= 2'h0;
        cmd   <= wcmd;
        done  <= 1'b0;
        if (!allowed) begin
          refused <= 1'b1;
        end else begin
          refused <= 1'b0;
          busy    <= 1'b1;
          if (wcmd == `FSPC_CMD_PROGRAM) begin
            state <= ST_PROG;
          end else if (wcmd == `FSPC_CMD_OPTION) begin
            opt_new <= data_reg;
            if (rdp && !data_reg[`FSPC_OPT_RDP_BIT]) begin
              walk     <= MEM_BASE;
              walk_end <= 16'hFFFF;
              state    <= ST_ERASE;
            end else begin
              state <= ST_OPT;
            end
          end else if (wcmd == `FSPC_CMD_MASS) begin
            walk     <= MEM_BASE;
            walk_end <= 16'hFFFF;
            state    <= ST_ERASE;
          end else if (sector == 2'h0) begin
            walk     <= `FSPC_SEC0_BASE;
            walk_end <= 16'hFFFF;
            state    <= ST_ERASE;
          end else if (sector == 2'h1) begin
            walk     <= `FSPC_SEC1_BASE;
            walk_end <= `FSPC_SEC0_BASE - 16'h0001;
            state    <= ST_ERASE;
          end else begin
            // Sector 2 runs from the base of the part up to just below sector 1.
            walk     <= MEM_BASE;
            walk_end <= `FSPC_SEC1_BASE - 16'h0001;
            state    <= ST_ERASE;
          end
        end
      end
      // The erase walks one byte a cycle, so a mass erase takes as many
      // cycles as the part has bytes; that was traded for a simple array.
      case (state)
        ST_IDLE: begin
          // Idle keeps whatever state a start above has just chosen.
        end
        ST_ERASE: begin
          arr_we    <= 1'b1;
          arr_addr  <= walk;
          arr_wdata <= `FSPC_ERASED;
          walk      <= walk + 16'h0001;
          if (walk == walk_end) begin
            state <= (cmd == `FSPC_CMD_OPTION) ? ST_OPT : ST_IDLE;
            if (cmd != `FSPC_CMD_OPTION) begin
              busy <= 1'b0;
              done <= 1'b1;
            end
          end
        end
        ST_PROG: begin
          // Only the target byte is written; its neighbours are left alone.
          arr_we    <= 1'b1;
          arr_addr  <= tgt;
          arr_wdata <= data_reg;
          busy      <= 1'b0;
          done      <= 1'b1;
          state     <= ST_IDLE;
        end
        ST_OPT: begin
          // The option only changes after any unlocking erase has run out.
          option <= opt_new;
          busy   <= 1'b0;
          done   <= 1'b1;
          state  <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read paths
  // ----------------------------------------------------------------------
  // The external path returns zero under protection so nothing can be
  // extracted. The array has its own read port, so external reads are
  // served even while the sequencer writes; a byte under erase may then
  // show either its old or its erased value.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      ext_rdata <= 8'h00;
    end else begin
      ext_rdata <= 8'h00;
      if (ext_read && !rdp) begin
        ext_rdata <= arr_rdata;
      end
      reg_rdata <= 8'h00;
      if (reg_read) begin
        if (reg_addr == `FSPC_ADDR_CTRL_STATUS) begin
          reg_rdata <= {done, armed, refused, busy, 1'b0, cmd, 1'b0};
        end else if (reg_addr == `FSPC_ADDR_ADDR_LO) begin
          reg_rdata <= addr_lo;
        end else if (reg_addr == `FSPC_ADDR_ADDR_HI) begin
          reg_rdata <= addr_hi;
        end else if (reg_addr == `FSPC_ADDR_DATA) begin
          reg_rdata <= data_reg;
        end else if (reg_addr == `FSPC_ADDR_OPTION) begin
          reg_rdata <= option;
        end
      end
    end
  end

endmodule // fspc_ctrl
`default_nettype wire

// ---- fspc_defines.vh ----
/*
  Constants for the flash sector protection controller: register offsets,
  field positions, reset values, mode codes and sector address bounds.
  Assumes inclusion by bare name from the controller source.
*/
`ifndef FSPC_DEFINES_VH
`define FSPC_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FSPC_ADDR_CTRL_STATUS  8'h2B
`define FSPC_ADDR_GUARD        8'h50
`define FSPC_ADDR_ADDR_LO      8'h51
`define FSPC_ADDR_ADDR_HI      8'h52
`define FSPC_ADDR_DATA         8'h53
`define FSPC_ADDR_OPTION       8'h54

// ----------------------------------------------------------------------
// Control/status fields
// ----------------------------------------------------------------------
`define FSPC_BIT_START    0
`define FSPC_BIT_CMD_LO   1
`define FSPC_BIT_CMD_HI   2
`define FSPC_BIT_BUSY     4
`define FSPC_BIT_REFUSED  5
`define FSPC_BIT_ARMED    6
`define FSPC_BIT_DONE     7

// Command codes in the two command bits.
`define FSPC_CMD_PROGRAM  2'h0
`define FSPC_CMD_SECTOR   2'h1
`define FSPC_CMD_MASS     2'h2
`define FSPC_CMD_OPTION   2'h3

// Guard unlock sequence.
`define FSPC_KEY1         8'h56
`define FSPC_KEY2         8'hAE

// Programming modes.
`define FSPC_MODE_TOOL    2'h0
`define FSPC_MODE_ICP     2'h1
`define FSPC_MODE_IAP     2'h2

// ----------------------------------------------------------------------
// Reset values and sector map
// ----------------------------------------------------------------------
`define FSPC_RST_CTRL     8'h00
`define FSPC_RST_OPTION   8'h00
`define FSPC_OPT_RDP_BIT  7
`define FSPC_SEC0_BASE    16'hF000
`define FSPC_SEC1_BASE    16'hE000
`define FSPC_ERASED       8'hFF

`endif

// ---- fspc_ctrl_monitor.sv ----
/*
  Port checker for the flash sector protection controller.
  Assumes it is bound to fspc_ctrl and shares its MEM_KB.
*/
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_monitor #(
  parameter int MEM_KB = 32
) (
  // Clock, reset and mode.
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [1:0]  prog_mode,
  // External read path and array.
  input wire logic        ext_read,
  input wire logic [7:0]  ext_rdata,
  input wire logic        arr_we,
  input wire logic [15:0] arr_addr,
  input wire logic [7:0]  arr_wdata,
  input wire logic [7:0]  arr_rdata,
  input wire logic        readout_protect_bit
);
  logic wiped;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // --------------------------------------------------------------
  // Helper: the top byte was erased while protection was still on.
  // --------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) wiped <= 1'b0;
    else if (!readout_protect_bit) wiped <= 1'b0;
    else if (arr_we && arr_addr == 16'hFFFF && arr_wdata == 8'hFF) wiped <= 1'b1;
  end
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  AST_RDP_EXT: assert property (readout_protect_bit && ext_read |=> ext_rdata == 8'h00)
    else $error("external read leaked data under protection");
  AST_EXT_OPEN: assert property (!readout_protect_bit && ext_read |=> ext_rdata == $past(arr_rdata))
    else $error("external read data wrong");
  AST_RDP_NOWR: assert property (arr_we && readout_protect_bit |-> arr_wdata == 8'hFF)
    else $error("array written under protection");
  AST_IAP_S0: assert property (arr_we && prog_mode == 2'h2 |-> arr_addr < 16'hF000)
    else $error("sector 0 changed in application mode");
  AST_MAP: assert property (arr_we |-> int'(arr_addr) >= 65536 - MEM_KB * 1024)
    else $error("write outside the fitted flash");
  AST_ASC: assert property (arr_we && $past(arr_we) |-> arr_addr == $past(arr_addr) + 16'h0001)
    else $error("erase address not ascending");
  AST_ERASE_FF: assert property (arr_we && $past(arr_we) |-> arr_wdata == 8'hFF)
    else $error("erase data not FF");
  AST_UNLOCK: assert property ($fell(readout_protect_bit) |-> wiped)
    else $error("protection cleared before full erase");
  COV_ERASE: cover property (arr_we [*2]);
  COV_UNLOCK: cover property ($fell(readout_protect_bit));
  COV_IAP: cover property (prog_mode == 2'h2 && arr_we);
endmodule // fspc_ctrl_monitor
bind fspc_ctrl fspc_ctrl_monitor #(.MEM_KB(MEM_KB)) u_mon (.core_clk, .resetn, .prog_mode,
  .ext_read, .ext_rdata, .arr_we, .arr_addr, .arr_wdata, .arr_rdata, .readout_protect_bit);
`default_nettype wire

// ---- fspc_flash_model.sv ----
/*
  Byte-wide flash array model, starting all zero.
  Assumes one write per strobe and an asynchronous read port.
*/
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_model (
  // Write side.
  input wire logic        core_clk,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  // Read side.
  input wire logic [15:0] raddr,
  output logic     [7:0]  rdata
);
  logic [7:0] mem [0:65535];
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  // Only the addressed byte changes, so neighbouring sectors stay intact.
  always @(posedge core_clk) if (we) mem[addr] <= wdata;
  assign rdata = mem[raddr];
endmodule // fspc_flash_model
`default_nettype wire

// ---- tb_flash_sector_protection_ctrl.sv ----
/*
  Self-checking bench for fspc_ctrl with an 8K array.
  Assumes fspc_defines.vh and the flash model are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defines.vh"
module tb_flash_sector_protection_ctrl;
  logic        core_clk = 0, resetn = 0, reg_write = 0, reg_read = 0, ext_read = 0;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, ext_rdata, arr_wdata, arr_rdata, d1, d2;
  logic [1:0]  prog_mode = 0;
  logic [15:0] ext_addr = 0, arr_addr;
  logic        arr_we, readout_protect_bit, rp = 0, xp = 0;
  logic [15:0] rq[$];
  logic [7:0]  xq[$];
  logic [31:0] r = 32'h773E;
  int          n_fail = 0, n_compared = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  fspc_ctrl #(.MEM_KB(8)) uut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .prog_mode, .ext_read, .ext_addr, .ext_rdata, .arr_we,
    .arr_addr, .arr_wdata, .arr_rdata, .readout_protect_bit);
  fspc_flash_model u_flash (.core_clk, .we(arr_we), .addr(arr_addr), .wdata(arr_wdata),
    .raddr(ext_addr), .rdata(arr_rdata));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task tally_and_finish;
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk_reg(input logic [15:0] e);
    n_compared++;
    if ((reg_rdata & e[7:0]) !== e[15:8]) begin
      n_fail++;
      $display("ERROR %0t register read %h expected %h", $time, reg_rdata, e[15:8]);
    end
  endtask
  task chk_ext(input logic [7:0] e);
    n_compared++;
    if (ext_rdata !== e) begin
      n_fail++;
      $display("ERROR %0t external read %h expected %h", $time, ext_rdata, e);
    end
  endtask
  task chk_rdp(input logic e);
    n_compared++;
    if (readout_protect_bit !== e) begin
      n_fail++;
      $display("ERROR %0t protection bit %b expected %b", $time, readout_protect_bit, e);
    end
  endtask
  task drv(input logic w, rr, x, input logic [7:0] a, dd);
    reg_write <= w;
    reg_read <= rr;
    ext_read <= x;
    reg_addr <= a;
    reg_wdata <= dd;
    @(posedge core_clk);
  endtask
  // Each read is followed by an idle cycle so no strobe lingers unnoted.
  task rd(input logic [7:0] a, e, m);
    rq.push_back({e, m});
    drv(0, 1, 0, a, 8'h00);
    drv(0, 0, 0, 8'h00, 8'h00);
  endtask
  task xr(input logic [15:0] t, input logic [7:0] e);
    xq.push_back(e);
    ext_addr <= t;
    drv(0, 0, 1, 8'h00, 8'h00);
    drv(0, 0, 0, 8'h00, 8'h00);
  endtask
  task op(input logic [15:0] t, input logic [7:0] dd, input logic [1:0] c, input logic k, ok);
    int n;
    n = 0;
    drv(1, 0, 0, `FSPC_ADDR_ADDR_LO, t[7:0]);
    drv(1, 0, 0, `FSPC_ADDR_ADDR_HI, t[15:8]);
    drv(1, 0, 0, `FSPC_ADDR_DATA, dd);
    if (k) begin
      drv(1, 0, 0, `FSPC_ADDR_GUARD, `FSPC_KEY1);
      drv(1, 0, 0, `FSPC_ADDR_GUARD, `FSPC_KEY2);
      rd(`FSPC_ADDR_CTRL_STATUS, 8'h40, 8'h40);
    end
    drv(1, 0, 0, `FSPC_ADDR_CTRL_STATUS, {5'h00, c, 1'b1});
    drv(0, 0, 0, 8'h00, 8'h00);
    repeat (3) @(posedge core_clk);
    while (arr_we === 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (3) @(posedge core_clk);
    rd(`FSPC_ADDR_CTRL_STATUS, ok ? 8'h80 : 8'h20, ok ? 8'hF0 : 8'h70);
  endtask
  // --------------------------------------------------------------
  // Result watcher: read data stand one cycle after the strobe.
  // --------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (rp) begin
      chk_reg(rq.pop_front());
    end
    if (xp) begin
      chk_ext(xq.pop_front());
    end
    rp = reg_read;
    xp = ext_read;
    if (cyc > 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd(`FSPC_ADDR_CTRL_STATUS, `FSPC_RST_CTRL, 8'hFF);
    rd(`FSPC_ADDR_OPTION, `FSPC_RST_OPTION, 8'hFF);
    chk_rdp(1'b0);
    drv(1, 0, 0, 8'h60, 8'h5A);
    rd(8'h60, 8'h00, 8'hFF);
    r = lfsr(r);
    d1 = r[7:0];
    r = lfsr(r);
    d2 = r[7:0];
    op(16'hF123, d1, `FSPC_CMD_PROGRAM, 1, 1);
    xr(16'hF123, d1);
    prog_mode <= `FSPC_MODE_ICP;
    op(16'hE010, d2, `FSPC_CMD_PROGRAM, 1, 1);
    xr(16'hE010, d2);
    prog_mode <= `FSPC_MODE_IAP;
    op(16'hF124, d2, `FSPC_CMD_PROGRAM, 1, 0);
    op(16'hF000, 8'h00, `FSPC_CMD_SECTOR, 1, 0);
    op(16'h0000, 8'h00, `FSPC_CMD_MASS, 1, 0);
    op(16'hE800, 8'h00, `FSPC_CMD_SECTOR, 1, 1);
    xr(16'hE010, `FSPC_ERASED);
    xr(16'hF123, d1);
    xr(16'hF124, 8'h00);
    prog_mode <= `FSPC_MODE_TOOL;
    op(16'hE020, d1, `FSPC_CMD_PROGRAM, 0, 0);
    op(16'h1000, d1, `FSPC_CMD_PROGRAM, 1, 0);
    op(16'h8000, 8'h00, `FSPC_CMD_SECTOR, 1, 0);
    op(16'h0000, 8'h80, `FSPC_CMD_OPTION, 1, 1);
    rd(`FSPC_ADDR_OPTION, 8'h80, 8'hFF);
    chk_rdp(1'b1);
    xr(16'hF123, 8'h00);
    op(16'hE020, d1, `FSPC_CMD_PROGRAM, 1, 0);
    op(16'h0000, 8'h00, `FSPC_CMD_OPTION, 1, 1);
    rd(`FSPC_ADDR_OPTION, 8'h00, 8'hFF);
    chk_rdp(1'b0);
    xr(16'hF123, `FSPC_ERASED);
    xr(16'hE000, `FSPC_ERASED);
    tally_and_finish();
  end
endmodule // tb_flash_sector_protection_ctrl
`default_nettype wire
